// [mlse_defines.svh]
/*
  Register offsets, field positions and reset values of the link status
  and event block. Assumes byte addresses on a 32-bit APB.
*/
`ifndef MLSE_DEFINES_SVH
`define MLSE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MLSE_OFS_PHY_LINK_STATE   8'h00
`define MLSE_OFS_LINK_EVT_RAW     8'h04
`define MLSE_OFS_LINK_EVT_MASKED  8'h08
`define MLSE_OFS_USER_EVT_RAW     8'h0C
`define MLSE_OFS_USER_EVT_MASKED  8'h10
`define MLSE_OFS_USER_MASK_SET    8'h14
`define MLSE_OFS_USER_MASK_CLEAR  8'h18
`define MLSE_OFS_MON_SEL_0        8'h1C
`define MLSE_OFS_MON_SEL_1        8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MLSE_SEL_ADDR_LSB         0
`define MLSE_SEL_ADDR_MSB         4
`define MLSE_SEL_IRQ_EN_BIT       6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MLSE_RST_LINK_STATE       32'h0000_0000
`define MLSE_RST_EVT              2'h0
`define MLSE_RST_SEL_ADDR         5'h00

`endif

// [mlse_phy_model.sv]
/*
  Frame engine and transceiver stand-in: one status read or command done per frame.
  Assumes its caller waits for each frame task to return.
*/
`timescale 1ns/1ps

module mlse_phy_model (
  output mlse_pkg::mlse_link_t link_o
);
  initial link_o = '0;

  // ------------------------------------------------------------------
  // One MDC period of done, one rising edge inside it
  // ------------------------------------------------------------------
  task automatic frame(input logic p, input logic [4:0] a, input logic k,
                       input logic l, input logic [1:0] u);
    #1.3;
    #80 link_o.mdc = 1'b1;
    #80 link_o.mdc = 1'b0;
    link_o.poll      = '{addr: a, ack: k, link: l};
    link_o.poll_done = p;
    link_o.user_done = u;
    #80 link_o.mdc = 1'b1;
    #80 link_o.mdc = 1'b0;
    // Released result lines flip so stale values never look valid
    link_o.poll_done = 1'b0;
    link_o.user_done = 2'h0;
    link_o.poll      = ~link_o.poll;
  endtask
endmodule

// [mlse_pkg.sv]
/*
  Types of the link status and event block.
  Assumes mlse_defines.svh is available to the design files.
*/
package mlse_pkg;

  // Result of one finished generic status read
  typedef struct packed {
    logic [4:0] addr;
    logic       ack;
    logic       link;
  } mlse_poll_t;

  // One monitored address select channel
  typedef struct packed {
    logic       irq_en;
    logic [4:0] addr;
  } mlse_sel_t;

  // Everything that crosses from the management link side
  typedef struct packed {
    logic       mdc;
    logic       poll_done;
    mlse_poll_t poll;
    logic [1:0] user_done;
  } mlse_link_t;

endpackage

// [mlse_sync.sv]
/*
  Three-stage synchroniser for a bundle of levels from another domain.
  Assumes the sender holds each level long enough to be sampled twice.
*/
`timescale 1ns/1ps

module mlse_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] agree;

  // Refused at elaboration, not at run time
  if (WIDTH < 1) begin : g_bad_width
    $error("mlse_sync: WIDTH must be at least 1");
  end

  // A bit moves only once stages two and three agree
  assign agree  = ~(s2_r ^ s3_r);
  assign sync_o = out_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      out_r  <= '0;
    end else begin
      meta_r <= async_i;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
      out_r  <= (agree & s3_r) | (~agree & out_r);
    end
  end

endmodule

// [mlse_top.sv]
/*
  Link state vector, link change events and user command complete events,
  reached over APB.
  Assumes the frame engine holds poll results and done levels stable for
  one whole management clock period, from one falling MDC edge to the next.
*/
// Functional notes
// [R1] A 32-bit link state vector holds one bit per transceiver address, refreshed per status read.
// [R2] A status read sets the address bit only when it was acknowledged and reported link.
// [R3] A status read clears the address bit on no link or a missing acknowledge.
// [R4] Writes to the link state vector are ignored and it resets to zero.
// [R5] A raw link change bit is set when the state of a monitored address changes, bit n for select n.
// [R6] Writing one clears a raw link change bit and writing zero leaves it.
// [R7] A masked link change bit is set only for a raw event whose enable is set, and write one clears it.
// [R8] Masked link change bit n belongs to monitored select n as the raw bits do.
// [R9] Raw command complete bit n is set when user channel n finishes its transaction.
// [R10] Writing one clears a raw command complete bit and writing zero leaves it.
// [R11] Bits 31 to 2 of the four event registers read as zero.
// [R12] A masked command complete bit is set only for a raw event with its mask enabled, write one clears.
// [R13] Mask set enables and mask clear disables a channel per bit written one, zeros do nothing.
// [R14] A change is found by comparing the new bit of a monitored address with its stored value.
// [R15] Link and user interrupt outputs are high while any matching masked bit is set.
`timescale 1ns/1ps
`include "mlse_defines.svh"

module mlse_top (
  input  wire logic        MCLK_I,
  input  wire logic        RESET_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Management link side
  input  wire logic        MDC_I,
  input  wire logic        POLL_DONE_I,
  input  wire logic [4:0]  POLL_ADDR_I,
  input  wire logic        POLL_ACK_I,
  input  wire logic        POLL_LINK_I,
  input  wire logic [1:0]  USER_DONE_I,
  // Towards the frame engine and the system
  output logic      [4:0]  MON_SEL0_ADDR_O,
  output logic      [4:0]  MON_SEL1_ADDR_O,
  output logic             LINK_IRQ_O,
  output logic             USER_IRQ_O
);

  // ----------------------------------------------------------------------
  // Link side crossing
  // ----------------------------------------------------------------------
  localparam int LINK_W = $bits(mlse_pkg::mlse_link_t);

  mlse_pkg::mlse_link_t link_async;
  mlse_pkg::mlse_link_t link_sync;
  logic                 mdc_prev_r;
  logic                 mdc_rise;
  logic                 poll_evt;
  logic [1:0]           user_evt;

  assign link_async = '{mdc:       MDC_I,
                        poll_done: POLL_DONE_I,
                        poll:      '{addr: POLL_ADDR_I,
                                     ack:  POLL_ACK_I,
                                     link: POLL_LINK_I},
                        user_done: USER_DONE_I};

  mlse_sync #(
    .WIDTH (LINK_W)
  ) u_sync (
    .clk_i   (MCLK_I),
    .rst_i   (RESET_I),
    .async_i (link_async),
    .sync_o  (link_sync)
  );

  // One rising MDC edge per period, so a done level yields one event
  assign mdc_rise = link_sync.mdc & ~mdc_prev_r;
  assign poll_evt = mdc_rise & link_sync.poll_done;
  assign user_evt = {2{mdc_rise}} & link_sync.user_done;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic        setup_ph;
  logic        wr_acc;
  logic        hit_state;
  logic        hit_lraw;
  logic        hit_lmsk;
  logic        hit_uraw;
  logic        hit_umsk;
  logic        hit_mset;
  logic        hit_mclr;
  logic        hit_sel0;
  logic        hit_sel1;
  logic        hit_any;
  logic [1:0]  wr_low;

  function automatic logic wr_hit(input logic en, input logic hit);
    wr_hit = en & hit;
  endfunction

  assign setup_ph  = PSEL_I & ~PENABLE_I;
  // Write lands at the access edge, where pready is already high
  assign wr_acc    = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
  assign hit_state = (PADDR_I == `MLSE_OFS_PHY_LINK_STATE);
  assign hit_lraw  = (PADDR_I == `MLSE_OFS_LINK_EVT_RAW);
  assign hit_lmsk  = (PADDR_I == `MLSE_OFS_LINK_EVT_MASKED);
  assign hit_uraw  = (PADDR_I == `MLSE_OFS_USER_EVT_RAW);
  assign hit_umsk  = (PADDR_I == `MLSE_OFS_USER_EVT_MASKED);
  assign hit_mset  = (PADDR_I == `MLSE_OFS_USER_MASK_SET);
  assign hit_mclr  = (PADDR_I == `MLSE_OFS_USER_MASK_CLEAR);
  assign hit_sel0  = (PADDR_I == `MLSE_OFS_MON_SEL_0);
  assign hit_sel1  = (PADDR_I == `MLSE_OFS_MON_SEL_1);
  assign hit_any   = hit_state | hit_lraw | hit_lmsk | hit_uraw | hit_umsk
                   | hit_mset | hit_mclr | hit_sel0 | hit_sel1;
  assign wr_low    = PWDATA_I[1:0];

  // ----------------------------------------------------------------------
  // Link state vector
  // ----------------------------------------------------------------------
  logic [31:0]           link_state_r;
  logic [31:0]           link_state_nxt;
  logic                  new_bit;
  logic                  old_bit;
  mlse_pkg::mlse_sel_t   sel_r   [2];
  mlse_pkg::mlse_sel_t   sel_nxt [2];
  logic [1:0]            link_chg;

  assign new_bit = link_sync.poll.ack & link_sync.poll.link; // [R2] [R3]
  assign old_bit = link_state_r[link_sync.poll.addr];

  // Software writes never reach this vector
  always_comb begin
    link_state_nxt = link_state_r; // [R4]
    if (poll_evt) begin
      link_state_nxt[link_sync.poll.addr] = new_bit; // [R1]
    end
  end

  // Compare against the stored bit before it is overwritten
  assign link_chg[0] = poll_evt & (link_sync.poll.addr == sel_r[0].addr)
                     & (new_bit != old_bit); // [R14] [R5]
  assign link_chg[1] = poll_evt & (link_sync.poll.addr == sel_r[1].addr)
                     & (new_bit != old_bit); // [R14] [R5]

  // ----------------------------------------------------------------------
  // Monitored address selects
  // ----------------------------------------------------------------------
  function automatic mlse_pkg::mlse_sel_t sel_from(input logic [31:0] d);
    sel_from.addr   = d[`MLSE_SEL_ADDR_MSB:`MLSE_SEL_ADDR_LSB];
    sel_from.irq_en = d[`MLSE_SEL_IRQ_EN_BIT];
  endfunction

  function automatic logic [31:0] sel_to(input mlse_pkg::mlse_sel_t s);
    sel_to = '0;
    sel_to[`MLSE_SEL_ADDR_MSB:`MLSE_SEL_ADDR_LSB] = s.addr;
    sel_to[`MLSE_SEL_IRQ_EN_BIT] = s.irq_en;
  endfunction

  assign sel_nxt[0] = wr_hit(wr_acc, hit_sel0) ? sel_from(PWDATA_I) : sel_r[0];
  assign sel_nxt[1] = wr_hit(wr_acc, hit_sel1) ? sel_from(PWDATA_I) : sel_r[1];

  // ----------------------------------------------------------------------
  // Event registers
  // ----------------------------------------------------------------------
  logic [1:0] link_raw_r;
  logic [1:0] link_raw_nxt;
  logic [1:0] link_msk_r;
  logic [1:0] link_msk_nxt;
  logic [1:0] link_en;
  logic [1:0] user_raw_r;
  logic [1:0] user_raw_nxt;
  logic [1:0] user_msk_r;
  logic [1:0] user_msk_nxt;
  logic [1:0] user_en_r;
  logic [1:0] user_en_nxt;
  logic [1:0] clr_lraw;
  logic [1:0] clr_lmsk;
  logic [1:0] clr_uraw;
  logic [1:0] clr_umsk;

  // Sticky flag: a fresh event beats a clear in the same cycle
  function automatic logic [1:0] w1c(input logic [1:0] cur, input logic [1:0] set,
                                     input logic [1:0] clr);
    w1c = set | (cur & ~clr);
  endfunction

  assign clr_lraw = {2{wr_hit(wr_acc, hit_lraw)}} & wr_low;
  assign clr_lmsk = {2{wr_hit(wr_acc, hit_lmsk)}} & wr_low;
  assign clr_uraw = {2{wr_hit(wr_acc, hit_uraw)}} & wr_low;
  assign clr_umsk = {2{wr_hit(wr_acc, hit_umsk)}} & wr_low;
  assign link_en  = {sel_r[1].irq_en, sel_r[0].irq_en};

  assign link_raw_nxt = w1c(link_raw_r, link_chg, clr_lraw); // [R5] [R6]
  assign link_msk_nxt = w1c(link_msk_r, link_chg & link_en, clr_lmsk); // [R7] [R8]
  assign user_raw_nxt = w1c(user_raw_r, user_evt, clr_uraw); // [R9] [R10]
  assign user_msk_nxt = w1c(user_msk_r, user_evt & user_en_r, clr_umsk); // [R12]

  // Set and clear in one cycle is impossible, one address per access
  assign user_en_nxt = wr_hit(wr_acc, hit_mset) ? (user_en_r | wr_low)
                     : wr_hit(wr_acc, hit_mclr) ? (user_en_r & ~wr_low)
                     : user_en_r; // [R13]

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  logic [31:0] rd_data;

  always_comb begin
    rd_data = '0; // [R11]
    if (hit_state) begin
      rd_data = link_state_r;
    end else if (hit_lraw) begin
      rd_data[1:0] = link_raw_r;
    end else if (hit_lmsk) begin
      rd_data[1:0] = link_msk_r;
    end else if (hit_uraw) begin
      rd_data[1:0] = user_raw_r;
    end else if (hit_umsk) begin
      rd_data[1:0] = user_msk_r;
    end else if (hit_mset | hit_mclr) begin
      rd_data[1:0] = user_en_r;
    end else if (hit_sel0) begin
      rd_data = sel_to(sel_r[0]);
    end else if (hit_sel1) begin
      rd_data = sel_to(sel_r[1]);
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      link_state_r <= `MLSE_RST_LINK_STATE; // [R4]
      mdc_prev_r   <= 1'b0;
      link_raw_r   <= `MLSE_RST_EVT;
      link_msk_r   <= `MLSE_RST_EVT;
      user_raw_r   <= `MLSE_RST_EVT;
      user_msk_r   <= `MLSE_RST_EVT;
      user_en_r    <= `MLSE_RST_EVT;
      sel_r[0]     <= '{irq_en: 1'b0, addr: `MLSE_RST_SEL_ADDR};
      sel_r[1]     <= '{irq_en: 1'b0, addr: `MLSE_RST_SEL_ADDR};
    end else begin
      link_state_r <= link_state_nxt;
      mdc_prev_r   <= link_sync.mdc;
      link_raw_r   <= link_raw_nxt;
      link_msk_r   <= link_msk_nxt;
      user_raw_r   <= user_raw_nxt;
      user_msk_r   <= user_msk_nxt;
      user_en_r    <= user_en_nxt;
      sel_r[0]     <= sel_nxt[0];
      sel_r[1]     <= sel_nxt[1];
    end
  end

  // Answer registered at setup: zero wait states, access lasts one cycle
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= setup_ph;
      PSLVERR_O <= setup_ph & ~hit_any;
      if (setup_ph) begin
        PRDATA_O <= (PWRITE_I | ~hit_any) ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // Interrupt lines take the masked flags' next values, so they change on the same edge as the flags
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      LINK_IRQ_O      <= 1'b0;
      USER_IRQ_O      <= 1'b0;
      MON_SEL0_ADDR_O <= `MLSE_RST_SEL_ADDR;
      MON_SEL1_ADDR_O <= `MLSE_RST_SEL_ADDR;
    end else begin
      LINK_IRQ_O      <= |link_msk_nxt; // [R15]
      USER_IRQ_O      <= |user_msk_nxt; // [R15]
      MON_SEL0_ADDR_O <= sel_nxt[0].addr;
      MON_SEL1_ADDR_O <= sel_nxt[1].addr;
    end
  end

endmodule

// [mlse_top_checker.sv]
/*
  Port checker of the link status and event block.
  Assumes it is bound to mlse_top and sees nothing but its ports.
*/
`timescale 1ns/1ps

module mlse_top_checker (
  input wire logic        MCLK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        POLL_DONE_I,
  input wire logic [1:0]  USER_DONE_I,
  input wire logic [4:0]  MON_SEL1_ADDR_O,
  input wire logic        LINK_IRQ_O,
  input wire logic        USER_IRQ_O
);
  // ------------------------------------------------------------------
  // Cycles since a done level was last high
  // ------------------------------------------------------------------
  logic [5:0] poll_age_r;
  logic [5:0] user_age_r;

  // Saturates so a long quiet spell never wraps into a false cause
  always_ff @(posedge MCLK_I) begin
    if (RESET_I || POLL_DONE_I) poll_age_r <= RESET_I ? 6'h3F : 6'h00;
    else poll_age_r <= poll_age_r + {5'h00, poll_age_r != 6'h3F};
    if (RESET_I || |USER_DONE_I) user_age_r <= RESET_I ? 6'h3F : 6'h00;
    else user_age_r <= user_age_r + {5'h00, user_age_r != 6'h3F};
  end

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_wr(logic [7:0] a);
    PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == a;
  endsequence
  sequence s_rd_evt;
    PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I &&
      PADDR_I inside {8'h04, 8'h08, 8'h0C, 8'h10};
  endsequence

  AST_RESET_QUIET: assert property (
    $fell(RESET_I) |-> !PREADY_O && !LINK_IRQ_O && !USER_IRQ_O && PRDATA_O == 32'h0)
    else $error("outputs not quiet after reset");
  AST_RSVD_ZERO: assert property (
    s_rd_evt |-> PRDATA_O[31:2] == 30'h0)
    else $error("reserved event bits not zero");
  AST_LSV_WR_QUIET: assert property (
    s_wr(8'h00) |-> !PSLVERR_O)
    else $error("write to link state refused");
  AST_LINK_IRQ_CAUSE: assert property (
    $rose(LINK_IRQ_O) |-> poll_age_r < 6'h14)
    else $error("link interrupt without status read");
  AST_USER_IRQ_CAUSE: assert property (
    $rose(USER_IRQ_O) |-> user_age_r < 6'h14)
    else $error("user interrupt without command done");
  AST_LINK_MASKED_CLR: assert property (
    s_wr(8'h08) ##0 (PWDATA_I[1:0] == 2'h3 && poll_age_r >= 6'h14) |-> ##2 !LINK_IRQ_O)
    else $error("link interrupt stays after clear");
  AST_USER_MASKED_CLR: assert property (
    s_wr(8'h10) ##0 (PWDATA_I[1:0] == 2'h3 && user_age_r >= 6'h14) |-> ##2 !USER_IRQ_O)
    else $error("user interrupt stays after clear");
  AST_SEL_COPY: assert property (
    s_wr(8'h20) |-> ##2 {27'h0, MON_SEL1_ADDR_O} == ($past(PWDATA_I, 2) & 32'h1F))
    else $error("select one address not copied");
endmodule

bind mlse_top mlse_top_checker i_chk (.MCLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .POLL_DONE_I, .USER_DONE_I,
  .MON_SEL1_ADDR_O, .LINK_IRQ_O, .USER_IRQ_O);

// [tb.sv]
/*
  Self-checking bench of the link status and event block.
  Assumes a one-cycle APB answer and the frame model beside it.
*/
`timescale 1ns/1ps

module tb;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} mlse_exp_t;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lirq;
  logic        uirq;
  logic [4:0]  sel0;
  logic [4:0]  sel1;
  logic [1:0]  le = 2'h1;
  logic [31:0] lk = 32'h0;
  logic [1:0]  er = 2'h0;
  logic [1:0]  em = 2'h0;
  logic [1:0]  ur = 2'h0;
  logic [1:0]  um = 2'h0;
  logic [1:0]  mk = 2'h0;
  logic [4:0]  a;
  mlse_pkg::mlse_link_t lnk;
  mlse_exp_t   q[$];
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          seed = 60844;

  mlse_top i_dut (.MCLK_I(mclk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MDC_I(lnk.mdc), .POLL_DONE_I(lnk.poll_done),
    .POLL_ADDR_I(lnk.poll.addr), .POLL_ACK_I(lnk.poll.ack), .POLL_LINK_I(lnk.poll.link),
    .USER_DONE_I(lnk.user_done), .MON_SEL0_ADDR_O(sel0), .MON_SEL1_ADDR_O(sel1),
    .LINK_IRQ_O(lirq), .USER_IRQ_O(uirq));
  mlse_phy_model i_phy (.link_o(lnk));

  always #2 mclk = ~mclk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------------
  // APB master; one idle edge after each transfer
  // ------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
    q.push_back('{d, m, e});
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= w ? d : $random(seed);
    @(posedge mclk);
    pen <= 1'b1;
    // Ends when pready is seen high; only the bench timeout ends a wait that never sees it
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b0, ad, d, 32'hFFFF_FFFF, 1'b0);
  endtask

  // Select 0 watches address 3, select 1 address 10; le mirrors their enables
  task automatic frame_chk(input logic p, input logic [4:0] fa, input logic k,
                           input logic l, input logic [1:0] u);
    if (p && fa == 5'h03 && (k & l) != lk[3]) begin
      er[0] = 1'b1;
      em[0] = em[0] | le[0];
    end
    if (p && fa == 5'h0A && (k & l) != lk[10]) begin
      er[1] = 1'b1;
      em[1] = em[1] | le[1];
    end
    if (p) lk[fa] = k & l;
    ur |= u;
    um |= u & mk;
    i_phy.frame(p, fa, k, l, u);
    repeat (6) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    if (psel && pen && pready === 1'b1) begin
      mlse_exp_t x;
      x = q.pop_front();
      cmp(prdata & x.m, x.d & x.m);
      cmp({31'h0, pslverr}, {31'h0, x.e});
    end
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
    wr(8'h00, $random(seed));
    rd(8'h00, 32'h0);
    xfer(1'b0, 8'h24 + 8'(4 * ({$random(seed)} % 55)), 32'h0, 32'hFFFF_FFFF, 1'b1);
    $display("test reset_and_map done");
    wr(8'h1C, 32'h43);
    wr(8'h20, 32'h0A);
    rd(8'h20, 32'h0A);
    cmp({27'h0, sel0}, 32'h3);
    cmp({27'h0, sel1}, 32'hA);
    for (int k = 0; k < 9; k++) begin
      a = (k % 3 == 0) ? 5'h03 : (k % 3 == 1) ? 5'h0A : 5'($random(seed));
      frame_chk(1'b1, a, k < 2 || 1'($random(seed)), k < 2 || 1'($random(seed)), 2'h0);
      rd(8'h00, lk);
      rd(8'h04, {30'h0, er});
      rd(8'h08, {30'h0, em});
      cmp({31'h0, lirq}, {31'h0, |em});
    end
    wr(8'h04, 32'h1);
    er[0] = 1'b0;
    wr(8'h04, 32'h0);
    rd(8'h04, {30'h0, er});
    wr(8'h08, 32'h3);
    em = 2'h0;
    rd(8'h08, 32'h0);
    cmp({31'h0, lirq}, 32'h0);
    // Second channel with its enable: masked bit 1 must follow select 1
    wr(8'h20, 32'h4A);
    le = 2'h3;
    frame_chk(1'b1, 5'h0A, 1'b1, ~lk[10], 2'h0);
    rd(8'h04, {30'h0, er});
    rd(8'h08, {30'h0, em});
    cmp({31'h0, lirq}, 32'h1);
    wr(8'h08, 32'h3);
    em = 2'h0;
    cmp({31'h0, lirq}, 32'h0);
    $display("test link_events done");
    wr(8'h14, 32'h1);
    mk = 2'h1;
    rd(8'h18, 32'h1);
    frame_chk(1'b0, 5'h00, 1'b0, 1'b0, 2'h3);
    rd(8'h0C, {30'h0, ur});
    rd(8'h10, {30'h0, um});
    cmp({31'h0, uirq}, 32'h1);
    wr(8'h18, 32'h1);
    mk = 2'h0;
    wr(8'h14, 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h0C, 32'h2);
    ur[1] = 1'b0;
    rd(8'h0C, {30'h0, ur});
    wr(8'h10, 32'h3);
    um = 2'h0;
    rd(8'h10, 32'h0);
    cmp({31'h0, uirq}, 32'h0);
    wr(8'h14, 32'h2);
    mk = 2'h2;
    frame_chk(1'b0, 5'h00, 1'b0, 1'b0, 2'h2);
    rd(8'h10, {30'h0, um});
    $display("test user_events done");
    stop_test();
  end
endmodule
